//--- pkg/etc_pkg.sv
// Shared constants, field layout and decode function of the eight-bit timer/counter
package etc_pkg;
   localparam int         WB_AW        = 8;
   localparam int         WB_DW        = 32;
   localparam int         WB_SW        = 4;
   localparam logic [7:0] ADR_CONFIG   = 8'h00;
   localparam logic [7:0] ADR_COUNT    = 8'h04;
   localparam logic [7:0] ADR_STATUS   = 8'h08;
   localparam logic [7:0] ADR_IEN      = 8'h0c;
   localparam int         CFG_RATE_LSB = 0;
   localparam int         RATE_W       = 3;
   localparam int         CFG_BYP_BIT  = 3;
   localparam int         CFG_SE_BIT   = 4;
   localparam int         CFG_CS_BIT   = 5;
   localparam int         CFG_W        = 6;
   localparam logic [5:0] CFG_RST      = 6'h3f;
   localparam int         CNT_W        = 8;
   localparam logic [7:0] CNT_RST      = 8'h00;
   localparam logic [7:0] CNT_STEP     = 8'h01;
   localparam logic [7:0] CNT_MAX      = 8'hff;
   localparam int         STS_OVF_BIT  = 0;
   localparam int         IEN_OVF_BIT  = 0;
   localparam logic       FLAG_RST     = 1'b0;
   localparam logic       SMP_RST      = 1'b1;
   localparam logic       IEN_RST      = 1'b0;
   localparam int         PH_W         = 2;
   localparam logic [1:0] PH_RST       = 2'h0;
   localparam logic [1:0] PH_STEP      = 2'h1;
   localparam logic [1:0] PH_Q2        = 2'h1;
   localparam logic [1:0] PH_Q4        = 2'h3;
   localparam int         INH_W        = 2;
   localparam logic [1:0] INH_CYCLES   = 2'h2;
   localparam logic [1:0] INH_STEP     = 2'h1;
   localparam logic [1:0] INH_NONE     = 2'h0;
   localparam int         PSC_W        = 8;
   localparam logic [7:0] PSC_RST      = 8'h00;
   localparam logic [7:0] PSC_STEP     = 8'h01;
   localparam logic [7:0] PSC_FULL     = 8'hff;
   localparam logic [2:0] RATE_TOP     = 3'h7;

   // Low prescaler bits that must all be set for one output event
   function automatic logic [PSC_W-1:0] etc_rate_mask(input logic [RATE_W-1:0] rate);
      etc_rate_mask = PSC_FULL >> (RATE_TOP - rate);
   endfunction
endpackage

//--- pkg/etc_psc_if.sv
// Connection between the timer core and its prescaler
`timescale 1ns/1ps
interface etc_psc_if;
   logic                      evt;
   logic                      src_lvl;
   logic                      clr;
   logic                      bypass;
   logic [etc_pkg::RATE_W-1:0] rate;
   logic                      pulse;
   logic                      level;
   modport ctl (output evt, output src_lvl, output clr, output bypass, output rate, input pulse, input level);
   modport psc (input evt, input src_lvl, input clr, input bypass, input rate, output pulse, output level);
endinterface

//--- core/etc_phase_sync.sv
// Instruction phase generator and external count pin synchroniser
`timescale 1ns/1ps
module etc_phase_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ext_pin_i,
   input  wire logic edge_sel_i,
   output logic      q2_o,
   output logic      q4_o,
   output logic      ext_lvl_o,
   output logic      ext_edge_o
);
   typedef struct packed {
      logic [etc_pkg::PH_W-1:0] phase;
      logic                     meta;
      logic                     sync;
      logic                     prev;
   } etc_sync_s;

   etc_sync_s state_ff;
   etc_sync_s nxt_state;

   always_comb begin
      nxt_state       = state_ff;
      nxt_state.phase = state_ff.phase + etc_pkg::PH_STEP;
      nxt_state.meta  = ext_pin_i;
      nxt_state.sync  = state_ff.meta;
      nxt_state.prev  = state_ff.sync ^ edge_sel_i;
      q2_o            = (state_ff.phase == etc_pkg::PH_Q2);
      q4_o            = (state_ff.phase == etc_pkg::PH_Q4);
      ext_lvl_o       = state_ff.sync ^ edge_sel_i;
      ext_edge_o      = ext_lvl_o && !state_ff.prev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff      <= '0;
         // Start at the counting level, so reset never yields a phantom edge
         state_ff.prev <= etc_pkg::SMP_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule

//--- core/etc_prescaler.sv
// Programmable power-of-two prescaler private to the timer
`timescale 1ns/1ps
module etc_prescaler (
   input  wire logic clk_i,
   input  wire logic rst_i,
   etc_psc_if.psc    psc
);
   typedef struct packed {
      logic [etc_pkg::PSC_W-1:0] cnt;
   } etc_psc_s;

   etc_psc_s                  state_ff;
   etc_psc_s                  nxt_state;
   logic [etc_pkg::PSC_W-1:0] mask;

   always_comb begin
      mask      = etc_pkg::etc_rate_mask(psc.rate);
      nxt_state = state_ff;
      if (psc.clr) begin
         nxt_state.cnt = etc_pkg::PSC_RST;
      end else if (psc.evt && !psc.bypass) begin
         nxt_state.cnt = state_ff.cnt + etc_pkg::PSC_STEP;
      end
      // Divide by 2^(rate+1): event when all masked bits are set
      psc.pulse = psc.evt && (psc.bypass || ((state_ff.cnt & mask) == mask));
      // Level form for the counter-mode phase sampler
      psc.level = psc.bypass ? psc.src_lvl : state_ff.cnt[psc.rate];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule

//--- core/etc_timer_counter.sv
// Eight-bit timer/counter core with classic Wishbone register slave
//
// How it works
// - Source select clear and bypass set: count once per instruction cycle.
// - After a count register write, skip increments for two instruction cycles.
// - Source select set: count selected edges of the external count pin.
// - Edge select chooses rising or falling transition as the counting edge.
// - Bypass clear routes the source through a prescaler private to this timer.
// - Three-bit rate field picks one of eight ratios, 1:2 through 1:256.
// - Bypass set skips the prescaler, counting every source event.
// - The prescaler count has no register address at all.
// - Writing the count register also clears the prescaler count.
// - Wrap from ff to 00 raises the overflow interrupt request.
// - Overflow flag sets on every wrap, whatever the enable.
// - Only software clears the overflow flag, never the counting logic.
// - Overflow reaches the interrupt output only when its enable is set.
// - External count edges sample prescaler output at phases Q2 and Q4.
// - Sleep freezes counter and prescaler, so no overflow occurs.
// - An overflow pulse output is offered as a gate source for another timer.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module etc_timer_counter (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [etc_pkg::WB_AW-1:0] wb_adr_i,
   input  wire logic [etc_pkg::WB_SW-1:0] wb_sel_i,
   input  wire logic [etc_pkg::WB_DW-1:0] wb_dat_i,
   output logic      [etc_pkg::WB_DW-1:0] wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      ext_count_input_i,
   input  wire logic                      sleep_i,
   output logic                           irq_o,
   output logic                           gate_src_o
);
   typedef struct packed {
      logic [etc_pkg::CFG_W-1:0] cfg;
      logic [etc_pkg::CNT_W-1:0] count;
      logic [etc_pkg::INH_W-1:0] inhibit;
      logic                      s2;
      logic                      s4;
      logic                      overflow_flag;
      logic                      overflow_irq_enable;
      logic                      ack;
      logic [etc_pkg::WB_DW-1:0] dat;
      logic                      irq;
      logic                      gate;
   } etc_regs_s;

   etc_regs_s                  state_ff;
   etc_regs_s                  nxt_state;

   logic                       req;
   logic                       take;
   logic                       wr_lo;
   logic                       cfg_wr;
   logic                       cnt_wr;
   logic                       ien_wr;
   logic                       sts_rd;
   logic                       count_source_select;
   logic                       count_edge_select;
   logic                       prescaler_bypass;
   logic [etc_pkg::RATE_W-1:0] prescale_rate;
   logic                       q2;
   logic                       q4;
   logic                       ext_lvl;
   logic                       ext_edge;
   logic                       awake;
   logic                       inc;
   logic                       inc_ok;
   logic                       ovf;

   etc_psc_if psc_bus ();

   // Register read word; anything unmapped reads as zero
   function automatic logic [etc_pkg::WB_DW-1:0] etc_rd_word(
      input logic [etc_pkg::WB_AW-1:0] adr,
      input etc_regs_s                 st
   );
      logic [etc_pkg::WB_DW-1:0] word;
      word = '0;
      case (adr)
         etc_pkg::ADR_CONFIG: begin
            word[etc_pkg::CFG_W-1:0] = st.cfg;
         end
         etc_pkg::ADR_COUNT: begin
            word[etc_pkg::CNT_W-1:0] = st.count;
         end
         etc_pkg::ADR_STATUS: begin
            word[etc_pkg::STS_OVF_BIT] = st.overflow_flag;
         end
         etc_pkg::ADR_IEN: begin
            word[etc_pkg::IEN_OVF_BIT] = st.overflow_irq_enable;
         end
         default: begin
            // Prescaler state is deliberately left off the map
            word = '0;
         end
      endcase
      etc_rd_word = word;
   endfunction

   etc_phase_sync u_phase (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ext_pin_i  (ext_count_input_i),
      .edge_sel_i (count_edge_select),
      .q2_o       (q2),
      .q4_o       (q4),
      .ext_lvl_o  (ext_lvl),
      .ext_edge_o (ext_edge)
   );

   etc_prescaler u_psc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .psc   (psc_bus.ctl)
   );

   // Configuration fields
   assign count_source_select = state_ff.cfg[etc_pkg::CFG_CS_BIT];
   assign count_edge_select   = state_ff.cfg[etc_pkg::CFG_SE_BIT];
   assign prescaler_bypass    = state_ff.cfg[etc_pkg::CFG_BYP_BIT];
   assign prescale_rate       = state_ff.cfg[etc_pkg::CFG_RATE_LSB +: etc_pkg::RATE_W];

   // Bus decode: a request is seen one edge, then completed at the edge
   // where the master samples ack, so writes land exactly with ack
   always_comb begin
      req    = wb_cyc_i && wb_stb_i;
      take   = req && state_ff.ack;
      wr_lo  = take && wb_we_i && wb_sel_i[0];
      cfg_wr = wr_lo && (wb_adr_i == etc_pkg::ADR_CONFIG);
      cnt_wr = wr_lo && (wb_adr_i == etc_pkg::ADR_COUNT);
      ien_wr = wr_lo && (wb_adr_i == etc_pkg::ADR_IEN);
      sts_rd = take && !wb_we_i && (wb_adr_i == etc_pkg::ADR_STATUS);
   end

   // Prescaler hookup
   always_comb begin
      awake = !sleep_i;
      psc_bus.evt = 1'b0;
      if (awake) begin
         if (count_source_select) begin
            psc_bus.evt = ext_edge;
         end else begin
            psc_bus.evt = q4;
         end
      end
      psc_bus.src_lvl = ext_lvl;
      psc_bus.clr     = cnt_wr;
      psc_bus.bypass  = prescaler_bypass;
      psc_bus.rate    = prescale_rate;
   end

   // Main next-state logic
   always_comb begin
      nxt_state = state_ff;

      // Bus answer: one-cycle ack, read data captured with it
      nxt_state.ack = req && !state_ff.ack;
      nxt_state.dat = '0;
      if (req && !state_ff.ack && !wb_we_i) begin
         nxt_state.dat = etc_rd_word(wb_adr_i, state_ff);
      end

      if (cfg_wr) begin
         nxt_state.cfg = wb_dat_i[etc_pkg::CFG_W-1:0];
      end
      if (ien_wr) begin
         nxt_state.overflow_irq_enable = wb_dat_i[etc_pkg::IEN_OVF_BIT];
      end

      // Counter-mode sync: level taken at Q2, confirmed at Q4, so an
      // edge can never land mid instruction cycle
      if (awake && q2) begin
         nxt_state.s2 = psc_bus.level;
      end
      if (awake && q4) begin
         nxt_state.s4 = state_ff.s2;
      end

      if (count_source_select) begin
         inc = awake && q4 && state_ff.s2 && !state_ff.s4;
      end else begin
         inc = awake && psc_bus.pulse;
      end

      // Write hold-off counts instruction ticks, frozen in sleep
      inc_ok = inc && (state_ff.inhibit == etc_pkg::INH_NONE) && !cnt_wr;
      if (cnt_wr) begin
         nxt_state.inhibit = etc_pkg::INH_CYCLES;
      end else if (awake && q4 && (state_ff.inhibit != etc_pkg::INH_NONE)) begin
         nxt_state.inhibit = state_ff.inhibit - etc_pkg::INH_STEP;
      end

      ovf = inc_ok && (state_ff.count == etc_pkg::CNT_MAX);
      if (cnt_wr) begin
         nxt_state.count = wb_dat_i[etc_pkg::CNT_W-1:0];
      end else if (inc_ok) begin
         nxt_state.count = state_ff.count + etc_pkg::CNT_STEP;
      end

      // Read clears only what the read reported; a new wrap still wins
      if (sts_rd && state_ff.dat[etc_pkg::STS_OVF_BIT]) begin
         nxt_state.overflow_flag = 1'b0;
      end
      if (ovf) begin
         nxt_state.overflow_flag = 1'b1;
      end

      nxt_state.irq  = nxt_state.overflow_flag && nxt_state.overflow_irq_enable;
      nxt_state.gate = ovf;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff                     <= '0;
         state_ff.cfg                 <= etc_pkg::CFG_RST;
         state_ff.count               <= etc_pkg::CNT_RST;
         state_ff.overflow_flag       <= etc_pkg::FLAG_RST;
         state_ff.overflow_irq_enable <= etc_pkg::IEN_RST;
         // Phase samplers start high: an idle pin must not count after reset
         state_ff.s2                  <= etc_pkg::SMP_RST;
         state_ff.s4                  <= etc_pkg::SMP_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign wb_dat_o   = state_ff.dat;
   assign wb_ack_o   = state_ff.ack;
   assign irq_o      = state_ff.irq;
   assign gate_src_o = state_ff.gate;
endmodule

//--- verification/etc_pin_model.sv
// Far-side model of the external count pin
`timescale 1ns/1ps
module etc_pin_model (
   input  wire logic clk_i,
   output logic      pin_o
);
   initial pin_o = 1'b0;

   // Each level held 8 clocks: beyond one instruction cycle plus the sync delay
   task automatic toggle(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (8) @(posedge clk_i);
         pin_o <= ~pin_o;
      end
   endtask
endmodule

//--- verification/etc_timer_counter_asserts.sv
// Port-level checks of the timer/counter
`timescale 1ns/1ps
module etc_timer_counter_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_count_input_i,
   input wire logic        sleep_i,
   input wire logic        irq_o,
   input wire logic        gate_src_o
);
   logic seen_ff;
   logic nxt_seen;
   logic st_rd;
   logic ien_wr;
   logic cnt_wr;
   assign st_rd  = wb_ack_o && !wb_we_i && wb_adr_i == etc_pkg::ADR_STATUS;
   assign ien_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == etc_pkg::ADR_IEN;
   assign cnt_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == etc_pkg::ADR_COUNT;

   // Wrap seen since last status read; clear wins so a racing wrap is not claimed
   always_comb begin
      nxt_seen = seen_ff;
      if (gate_src_o) nxt_seen = 1'b1;
      if (st_rd) nxt_seen = 1'b0;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) seen_ff <= 1'b0;
      else seen_ff <= nxt_seen;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_gate_pulse: assert property (gate_src_o |=> !gate_src_o [*3]) else $error("gate pulse too long");
   a_hold_off: assert property (cnt_wr |-> ##3 !gate_src_o [*7]) else $error("count moved in hold-off");
   a_sleep_frozen: assert property ($past(sleep_i) && $past(sleep_i, 2) |-> !gate_src_o) else $error("wrap in sleep");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c})
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_flag_sticky: assert property (st_rd && seen_ff |-> wb_dat_o[0]) else $error("flag lost");
   a_irq_cause: assert property ($rose(irq_o) |-> gate_src_o || $past(gate_src_o) || $past(ien_wr)
      || $past(ien_wr, 2)) else $error("irq without cause");
   a_irq_clear: assert property ($fell(irq_o) |-> $past(st_rd) || $past(st_rd, 2) || $past(ien_wr)
      || $past(ien_wr, 2)) else $error("irq dropped by hardware");
   a_count_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == etc_pkg::ADR_COUNT
      |-> wb_dat_o[31:8] == 24'h0) else $error("count wider than 8 bits");
endmodule

bind etc_timer_counter etc_timer_counter_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_count_input_i, .sleep_i, .irq_o, .gate_src_o);

//--- verification/tb_etc_timer_counter.sv
// Self-checking bench for the timer/counter over Wishbone
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_etc_timer_counter;
   logic        clk_i     = 1'b0;
   logic        rst_i     = 1'b1;
   logic        wb_cyc    = 1'b0;
   logic        wb_stb    = 1'b0;
   logic        wb_we     = 1'b0;
   logic [7:0]  wb_adr    = 8'h00;
   logic [3:0]  wb_sel    = 4'h0;
   logic [31:0] wb_wdat   = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        sleep     = 1'b0;
   logic        pin;
   logic        irq;
   logic        gate;
   int          err_count = 0;
   int          tests_run = 0;
   logic [31:0] q;
   logic [5:0]  ccfg [3]  = '{6'h28, 6'h38, 6'h20};
   int          ctog [3]  = '{5, 3, 8};
   logic [31:0] cexp [3]  = '{32'h3, 32'h2, 32'h2};

   always #12.5 clk_i = ~clk_i;

   etc_timer_counter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .ext_count_input_i(pin), .sleep_i(sleep), .irq_o(irq), .gate_src_o(gate));
   etc_pin_model u_pin (.clk_i(clk_i), .pin_o(pin));

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         wrap_up();
      end
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask

   // Clocks from the count write to the wrap pulse, counted from ff
   task automatic meas(input logic [5:0] cfg, input int lo, input int hi);
      int n;
      wr(etc_pkg::ADR_CONFIG, 32'(cfg));
      wr(etc_pkg::ADR_COUNT, 32'hff);
      n = 1;
      while (gate !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
      if (n >= 3000) begin
         wrap_up();
      end
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(etc_pkg::ADR_CONFIG, 32'h3f);
      rd(etc_pkg::ADR_COUNT, 32'h0);
      rd(etc_pkg::ADR_STATUS, 32'h0);
      rd(etc_pkg::ADR_IEN, 32'h0);
      rd(8'h10, 32'h0);
      wr(8'h10, 32'hff);
      rd(etc_pkg::ADR_CONFIG, 32'h3f);
      // Windows span the four tick phases; rate 0 loses its first output to the hold-off
      for (int r = 0; r < 8; r++) begin
         meas(6'(r), (r == 0) ? 14 : 4 * (2 << r) - 2, (r == 0) ? 17 : 4 * (2 << r) + 1);
      end
      meas(6'h08, 10, 13);
      `CHK(irq, 1'b0)
      rd(etc_pkg::ADR_STATUS, 32'h1);
      rd(etc_pkg::ADR_STATUS, 32'h0);
      wr(etc_pkg::ADR_IEN, 32'h1);
      meas(6'h08, 10, 13);
      @(posedge clk_i);
      `CHK(irq, 1'b1)
      rd(etc_pkg::ADR_STATUS, 32'h1);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
      wr(etc_pkg::ADR_IEN, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(etc_pkg::ADR_CONFIG, 32'(ccfg[i]));
         repeat (12) @(posedge clk_i);
         wr(etc_pkg::ADR_COUNT, 32'h0);
         repeat (12) @(posedge clk_i);
         u_pin.toggle(ctog[i]);
         repeat (12) @(posedge clk_i);
         rd(etc_pkg::ADR_COUNT, cexp[i]);
      end
      wr(etc_pkg::ADR_CONFIG, 32'h08);
      wr(etc_pkg::ADR_COUNT, 32'h40);
      sleep <= 1'b1;
      repeat (200) @(posedge clk_i);
      rd(etc_pkg::ADR_COUNT, 32'h40);
      sleep <= 1'b0;
      wrap_up();
   end
endmodule
